/* File: serial_cmd_pkg.sv */
// Purpose: shared constants and carrier types for the serial command checker
// Assumes: 16-bit register words, 8-bit characters
// Notes: address classes other than the commit and error detail words are
//        placed by this design

`default_nettype none

package serial_cmd_pkg;

  // ---------------------------------------------------------------
  // Function and exception codes
  // ---------------------------------------------------------------
  localparam logic [7:0] FC_READ = 8'h03;
  localparam logic [7:0] FC_LOOP = 8'h08;
  localparam logic [7:0] FC_WRITE = 8'h10;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_FUNC = 8'h01;
  localparam logic [7:0] EXC_REG = 8'h02;
  localparam logic [7:0] EXC_QTY = 8'h03;
  localparam logic [7:0] EXC_MODE = 8'h22;
  localparam logic [7:0] EXC_UV = 8'h23;
  localparam logic [7:0] EXC_BUSY = 8'h24;
  localparam logic [7:0] EXC_NONE = 8'h00;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [15:0] ADDR_COMMIT_NV = 16'h0900;
  localparam logic [15:0] ADDR_COMMIT_RAM = 16'h0910;
  localparam logic [15:0] ADDR_ERR_DETAIL = 16'h003D;
  localparam logic [15:0] ADDR_BCAST_A = 16'h0001;
  localparam logic [15:0] ADDR_BCAST_B = 16'h0002;
  localparam logic [15:0] REF_LO = 16'h0001;
  localparam logic [15:0] REF_HI = 16'h000F;
  localparam logic [15:0] MON_LO = 16'h0020;
  localparam logic [15:0] MON_HI = 16'h003F;
  localparam logic [15:0] FAULT_TRACE = 16'h0080;
  localparam logic [15:0] FAULT_HIST_LO = 16'h0090;
  localparam logic [15:0] PARAM_LO = 16'h0100;
  localparam logic [15:0] PARAM_HI = 16'h08FF;

  // ---------------------------------------------------------------
  // Frame limits, timing, CRC
  // ---------------------------------------------------------------
  localparam logic [7:0] BCAST_ADDR = 8'h00;
  localparam logic [15:0] MIN_REGS = 16'h0001;
  localparam logic [15:0] MAX_REGS = 16'h0010;
  localparam logic [7:0] MAX_BYTES = 8'h20;
  localparam int MAX_FRAME = 41;
  localparam logic [5:0] FIXED_LEN = 6'h08;
  localparam logic [5:0] WRITE_HDR = 6'h09;
  localparam logic [5:0] EXC_LEN = 6'h05;
  localparam logic [5:0] GAP_BITS = 6'h18;
  localparam logic [5:0] CHAR_BITS = 6'h0B;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;

  // ---------------------------------------------------------------
  // Fault codes and error detail bit positions
  // ---------------------------------------------------------------
  localparam logic [7:0] FAULT_POWER_UNIT = 8'h01;
  localparam logic [7:0] FAULT_BUS_UV = 8'h02;
  localparam logic [7:0] FAULT_DRIVE_HI = 8'h2A;
  localparam logic [7:0] FAULT_CPU_LO = 8'h83;
  localparam logic [7:0] FAULT_CPU_HI = 8'h94;
  localparam int ERRB_CRC = 0;
  localparam int ERRB_LEN = 1;
  localparam int ERRB_PAR = 3;
  localparam int ERRB_OVR = 4;
  localparam int ERRB_FRM = 5;
  localparam int ERRB_TMO = 6;

  // ---------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic overrun;
    logic framing;
    logic parity;
  } rx_flags_t;

  typedef struct packed {
    logic running;
    logic dc_bus_low_alarm;
    logic defective_eeprom_alarm;
    logic param_busy;
  } drive_status_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] data;
  } wr_port_t;

  typedef enum logic [2:0] {
    C_NONE, C_REF, C_MON, C_FAULT, C_PARAM, C_COMMIT
  } addr_class_t;

endpackage : serial_cmd_pkg

`default_nettype wire

/* File: serial_param_commit.sv */
// Purpose: checks serial register requests, stages parameter writes,
//          commits them and builds normal or exception replies
// Assumes: byte receiver and transmitter run on core_clk; bit_tick is one
//          pulse per bit time
// Notes: frames with line errors, long gaps or bad lengths get no reply

`timescale 1ns/1ps
`default_nettype none

module serial_param_commit
  import serial_cmd_pkg::*;
#(
  parameter logic [7:0] EXC_DATA = 8'h21,
  parameter logic [15:0] REF_MAX = 16'hFFFF,
  parameter logic [15:0] PARAM_MAX = 16'hFFFF,
  parameter logic [15:0] SAFE_LO = 16'h0100,
  parameter logic [15:0] SAFE_HI = 16'h0105,
  parameter logic [15:0] SAFE_X = 16'h0300,
  parameter logic [15:0] SAFE_Y = 16'h0500,
  parameter int HIST_DEPTH = 4
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] slave_addr,
  input wire logic bit_tick,
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  input wire serial_cmd_pkg::rx_flags_t rx_flags,
  input wire logic err_reset,
  input wire serial_cmd_pkg::drive_status_t drive,
  input wire logic fault_new,
  input wire logic [7:0] fault_code,
  input wire logic fault_clear,
  output logic [15:0] rd_addr,
  input wire logic [15:0] rd_data,
  output logic tx_valid,
  output logic [7:0] tx_byte,
  input wire logic tx_ready,
  output serial_cmd_pkg::wr_port_t stage_wr,
  output logic stage_we,
  output serial_cmd_pkg::wr_port_t ref_wr,
  output logic ref_we,
  output logic commit_nv,
  output logic commit_ram,
  output logic [7:0] comm_err,
  output logic [7:0] fault_trace
);

  typedef enum logic [2:0] {
    S_IDLE, S_RECV, S_SKIP, S_CHECK, S_FETCH, S_WRITE, S_SEND
  } state_t;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int k = 0; k < 8; k++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_step

  function automatic addr_class_t addr_class(input logic [15:0] a);
    if (a >= REF_LO && a <= REF_HI) return C_REF;
    if (a >= MON_LO && a <= MON_HI) return C_MON;
    if (a == FAULT_TRACE) return C_FAULT;
    if (a >= FAULT_HIST_LO && a < FAULT_HIST_LO + 16'(HIST_DEPTH)) begin
      return C_FAULT;
    end
    if (a >= PARAM_LO && a <= PARAM_HI) return C_PARAM;
    if (a == ADDR_COMMIT_NV || a == ADDR_COMMIT_RAM) return C_COMMIT;
    return C_NONE;
  endfunction : addr_class

  function automatic logic fault_known(input logic [7:0] c);
    return (c >= FAULT_POWER_UNIT && c <= FAULT_DRIVE_HI) ||
           (c >= FAULT_CPU_LO && c <= FAULT_CPU_HI);
  endfunction : fault_known

  // ---------------------------------------------------------------
  // State and frame decode
  // ---------------------------------------------------------------
  state_t state_q;
  logic [7:0] fr_q [MAX_FRAME];
  logic [15:0] wbuf_q [16];
  logic [7:0] hist_q [HIST_DEPTH];
  logic [5:0] n_q, len_q, ti_q, tlen_q, gap_q;
  logic [4:0] idx_q;
  logic ph_q;
  logic [7:0] exc_q, err_q, trace_q, tx_byte_q;
  logic [15:0] crc_rx_q, crc_tx_q, rd_addr_q;
  logic stage_we_q, ref_we_q, commit_nv_q, commit_ram_q;
  wr_port_t wr_q;

  logic [7:0] func;
  logic [15:0] start, qty, cur_addr, cur_data, crc_next, rd_word;
  logic [5:0] di, len_now, nxt;
  logic bcast, rx_bad, len_bad, gap_over, frame_done, last_word;
  logic [7:0] hdr_exc, word_exc, body_b, err_set;
  addr_class_t cls;

  assign func = fr_q[1];
  assign start = {fr_q[2], fr_q[3]};
  assign qty = {fr_q[4], fr_q[5]};
  assign bcast = fr_q[0] == BCAST_ADDR;
  assign cur_addr = start + {11'h000, idx_q};
  assign di = 6'h07 + {idx_q, 1'b0};
  assign cur_data = {fr_q[di], fr_q[di + 6'h01]};
  assign cls = addr_class(cur_addr);
  assign last_word = idx_q == 5'(qty - 16'h0001);
  assign rx_bad = |rx_flags;
  // Character time is inside the strobe spacing, so add it to the gap
  assign gap_over = gap_q > GAP_BITS + CHAR_BITS;
  assign len_bad = state_q == S_RECV && n_q == 6'h06 &&
                   func == FC_WRITE && rx_byte > MAX_BYTES;
  assign len_now = (n_q == 6'h06 && func == FC_WRITE) ?
                   WRITE_HDR + 6'(rx_byte) : len_q;
  assign crc_next = crc_step(state_q == S_IDLE ? CRC_INIT : crc_rx_q,
                             rx_byte);
  assign frame_done = state_q == S_RECV && rx_valid && !rx_bad &&
                      !len_bad && n_q >= 6'h07 &&
                      n_q + 6'h01 == len_now;

  // ---------------------------------------------------------------
  // Request checks
  // ---------------------------------------------------------------
  always_comb begin
    hdr_exc = EXC_NONE;
    if (func != FC_READ && func != FC_LOOP && func != FC_WRITE) begin
      hdr_exc = EXC_FUNC;
    end else if (func != FC_LOOP) begin
      if (qty < MIN_REGS || qty > MAX_REGS) begin
        hdr_exc = EXC_QTY;
      end else if (func == FC_WRITE && {8'h00, fr_q[6]} != {qty[14:0], 1'b0})
      begin
        hdr_exc = EXC_QTY;
      end else if (bcast && start != ADDR_BCAST_A && start != ADDR_BCAST_B)
      begin
        hdr_exc = EXC_REG;
      end
    end
  end

  always_comb begin
    word_exc = EXC_NONE;
    if (func == FC_READ) begin
      if (cls == C_NONE || cls == C_COMMIT) word_exc = EXC_REG;
    end else begin
      unique case (cls)
        C_NONE: word_exc = EXC_REG;
        C_MON, C_FAULT: word_exc = EXC_MODE;
        C_REF: if (cur_data > REF_MAX) word_exc = EXC_DATA;
        C_COMMIT: begin
          if (drive.running) word_exc = EXC_MODE;
          else if (drive.dc_bus_low_alarm) word_exc = EXC_UV;
          else if (cur_data != 16'h0000) word_exc = EXC_DATA;
        end
        C_PARAM: begin
          if (drive.running) word_exc = EXC_MODE;
          else if (drive.dc_bus_low_alarm) word_exc = EXC_UV;
          else if (drive.param_busy) word_exc = EXC_BUSY;
          else if (drive.defective_eeprom_alarm &&
                   !((cur_addr >= SAFE_LO && cur_addr <= SAFE_HI) ||
                     cur_addr == SAFE_X || cur_addr == SAFE_Y)) begin
            word_exc = EXC_MODE;
          end else if (cur_data > PARAM_MAX) word_exc = EXC_DATA;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_q <= S_IDLE;
      n_q <= 6'h00;
      len_q <= FIXED_LEN;
      idx_q <= 5'h00;
      ph_q <= 1'b0;
      exc_q <= EXC_NONE;
      ti_q <= 6'h00;
      tlen_q <= EXC_LEN;
    end else begin
      unique case (state_q)
        S_IDLE: if (rx_valid) begin
          state_q <= rx_bad ? S_SKIP : S_RECV;
          n_q <= 6'h01;
          len_q <= FIXED_LEN;
          exc_q <= EXC_NONE;
          ph_q <= 1'b0;
          idx_q <= 5'h00;
        end
        S_RECV: begin
          if (gap_over) state_q <= S_IDLE;
          else if (rx_valid) begin
            n_q <= n_q + 6'h01;
            len_q <= len_now;
            if (rx_bad || len_bad) state_q <= S_SKIP;
            else if (frame_done) begin
              state_q <= (crc_next == 16'h0000 &&
                          (bcast || fr_q[0] == slave_addr)) ?
                         S_CHECK : S_IDLE;
            end
          end
        end
        // Waits for line silence so the rest of a bad frame is not parsed
        S_SKIP: if (gap_over) state_q <= S_IDLE;
        S_CHECK: begin
          ti_q <= 6'h00;
          if (!ph_q) begin
            if (hdr_exc != EXC_NONE || (bcast && func != FC_WRITE)) begin
              exc_q <= hdr_exc;
              state_q <= bcast ? S_IDLE : S_SEND;
              tlen_q <= EXC_LEN;
            end else if (func == FC_LOOP) begin
              state_q <= S_SEND;
              tlen_q <= FIXED_LEN;
            end else ph_q <= 1'b1;
          end else if (word_exc != EXC_NONE) begin
            exc_q <= word_exc;
            state_q <= bcast ? S_IDLE : S_SEND;
            tlen_q <= EXC_LEN;
          end else if (last_word) begin
            idx_q <= 5'h00;
            ph_q <= 1'b0;
            state_q <= func == FC_READ ? S_FETCH : S_WRITE;
          end else idx_q <= idx_q + 5'h01;
        end
        S_FETCH: begin
          ph_q <= !ph_q;
          if (ph_q) begin
            idx_q <= idx_q + 5'h01;
            if (last_word) begin
              state_q <= S_SEND;
              tlen_q <= EXC_LEN + {qty[4:0], 1'b0};
            end
          end
        end
        S_WRITE: begin
          idx_q <= idx_q + 5'h01;
          if (last_word) begin
            state_q <= bcast ? S_IDLE : S_SEND;
            tlen_q <= FIXED_LEN;
          end
        end
        S_SEND: if (tx_ready) begin
          ti_q <= ti_q + 6'h01;
          if (ti_q == tlen_q - 6'h01) state_q <= S_IDLE;
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Frame capture, CRC and gap timer
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      for (int k = 0; k < MAX_FRAME; k++) fr_q[k] <= 8'h00;
    end else if (rx_valid && (state_q == S_IDLE ||
                 (state_q == S_RECV && n_q < 6'(MAX_FRAME)))) begin
      fr_q[state_q == S_IDLE ? 6'h00 : n_q] <= rx_byte;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) crc_rx_q <= CRC_INIT;
    else if (rx_valid) crc_rx_q <= crc_next;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n || rx_valid) gap_q <= 6'h00;
    else if (bit_tick && gap_q != 6'h3F) gap_q <= gap_q + 6'h01;
  end

  // ---------------------------------------------------------------
  // Link error details, set wins over reset
  // ---------------------------------------------------------------
  always_comb begin
    err_set = 8'h00;
    if (rx_valid && (state_q == S_IDLE || state_q == S_RECV)) begin
      err_set[ERRB_PAR] = rx_flags.parity;
      err_set[ERRB_OVR] = rx_flags.overrun;
      err_set[ERRB_FRM] = rx_flags.framing;
    end
    err_set[ERRB_LEN] = len_bad && rx_valid;
    err_set[ERRB_TMO] = state_q == S_RECV && gap_over;
    err_set[ERRB_CRC] = frame_done && crc_next != 16'h0000;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) err_q <= 8'h00;
    else err_q <= (err_reset ? 8'h00 : err_q) | err_set;
  end

  // ---------------------------------------------------------------
  // Fault trace and history
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      trace_q <= 8'h00;
      for (int k = 0; k < HIST_DEPTH; k++) hist_q[k] <= 8'h00;
    end else if (fault_new && fault_known(fault_code)) begin
      trace_q <= fault_code;
      hist_q[0] <= fault_code;
      for (int k = 1; k < HIST_DEPTH; k++) hist_q[k] <= hist_q[k - 1];
    end else if (fault_clear) trace_q <= 8'h00;
  end

  // ---------------------------------------------------------------
  // Read fetch
  // ---------------------------------------------------------------
  always_comb begin
    if (rd_addr_q == ADDR_ERR_DETAIL) rd_word = {8'h00, err_q};
    else if (rd_addr_q == FAULT_TRACE) rd_word = {8'h00, trace_q};
    else if (addr_class(rd_addr_q) == C_FAULT) begin
      rd_word = {8'h00, hist_q[2'(rd_addr_q - FAULT_HIST_LO)]};
    end else rd_word = rd_data;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) rd_addr_q <= 16'h0000;
    else if (state_q == S_FETCH && !ph_q) rd_addr_q <= cur_addr;
  end

  always_ff @(posedge core_clk) begin
    if (state_q == S_FETCH && ph_q) wbuf_q[idx_q[3:0]] <= rd_word;
  end

  // ---------------------------------------------------------------
  // Write strobes: staging, direct references and commits
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      stage_we_q <= 1'b0;
      ref_we_q <= 1'b0;
      commit_nv_q <= 1'b0;
      commit_ram_q <= 1'b0;
      wr_q <= '0;
    end else begin
      stage_we_q <= state_q == S_WRITE && cls == C_PARAM;
      ref_we_q <= state_q == S_WRITE && cls == C_REF;
      commit_nv_q <= state_q == S_WRITE &&
                     cur_addr == ADDR_COMMIT_NV;
      commit_ram_q <= state_q == S_WRITE &&
                      cur_addr == ADDR_COMMIT_RAM;
      if (state_q == S_WRITE) wr_q <= '{addr: cur_addr, data: cur_data};
    end
  end

  // ---------------------------------------------------------------
  // Reply builder
  // ---------------------------------------------------------------
  assign nxt = ti_q + 6'h01;

  always_comb begin
    if (exc_q != EXC_NONE) begin
      body_b = nxt == 6'h01 ? (fr_q[1] | EXC_FLAG) : exc_q;
    end else if (func == FC_READ) begin
      if (nxt == 6'h01) body_b = FC_READ;
      else if (nxt == 6'h02) body_b = {qty[6:0], 1'b0};
      else if (nxt[0]) body_b = wbuf_q[4'((nxt - 6'h03) >> 1)][15:8];
      else body_b = wbuf_q[4'((nxt - 6'h03) >> 1)][7:0];
    end else body_b = fr_q[nxt];
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tx_byte_q <= 8'h00;
      crc_tx_q <= CRC_INIT;
    end else if (state_q != S_SEND) begin
      tx_byte_q <= fr_q[0];
      crc_tx_q <= CRC_INIT;
    end else if (tx_ready) begin
      if (ti_q < tlen_q - 6'h02) begin
        crc_tx_q <= crc_step(crc_tx_q, tx_byte_q);
        tx_byte_q <= (ti_q == tlen_q - 6'h03) ?
                     8'(crc_step(crc_tx_q, tx_byte_q)) : body_b;
      end else if (ti_q == tlen_q - 6'h02) tx_byte_q <= crc_tx_q[15:8];
    end
  end

  assign tx_valid = state_q == S_SEND;
  assign tx_byte = tx_byte_q;
  assign rd_addr = rd_addr_q;
  assign stage_wr = wr_q;
  assign ref_wr = wr_q;
  assign stage_we = stage_we_q;
  assign ref_we = ref_we_q;
  assign commit_nv = commit_nv_q;
  assign commit_ram = commit_ram_q;
  assign comm_err = err_q;
  assign fault_trace = trace_q;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  commit_nv_cause_a: assert property (commit_nv |->
    $past(state_q == S_WRITE && cur_addr == ADDR_COMMIT_NV &&
          !drive.running && !drive.dc_bus_low_alarm))
    else $error("nonvolatile commit without a valid write");
  commit_ram_cause_a: assert property (commit_ram |->
    $past(state_q == S_WRITE && cur_addr == ADDR_COMMIT_RAM) && !commit_nv)
    else $error("ram commit without a valid write");
  commit_read_exc_a: assert property (
    state_q == S_CHECK && ph_q && func == FC_READ && cls == C_COMMIT
    |=> state_q == S_SEND && exc_q == EXC_REG)
    else $error("commit register read not refused");
  quantity_exc_a: assert property (
    state_q == S_CHECK && !ph_q && func == FC_READ && !bcast &&
    (qty == 16'h0000 || qty > MAX_REGS) |=> exc_q == EXC_QTY)
    else $error("bad quantity not refused");
  func_exc_a: assert property (
    state_q == S_CHECK && !ph_q && !bcast && func != FC_READ &&
    func != FC_LOOP && func != FC_WRITE
    |=> exc_q == EXC_FUNC ##[1:3] tx_valid)
    else $error("unknown function not refused");
  gap_discard_a: assert property (
    state_q == S_RECV && gap_over |=> state_q == S_IDLE && err_q[ERRB_TMO])
    else $error("long gap did not discard frame");
  bcast_silent_a: assert property (tx_valid |-> !bcast)
    else $error("reply sent to broadcast");
  err_sticky_a: assert property (!err_reset |=>
    (err_q & $past(err_q)) == $past(err_q))
    else $error("error detail lost without reset");
  exc_frame_a: assert property (
    tx_valid && ti_q == 6'h01 && exc_q != EXC_NONE
    |-> tx_byte == (fr_q[1] | EXC_FLAG))
    else $error("exception reply lacks flagged function");
  running_write_a: assert property (
    stage_we |-> $past(!drive.running && !drive.param_busy))
    else $error("parameter staged while refused");

endmodule : serial_param_commit

`default_nettype wire

/* File: master_model.sv */
// Purpose: serial master model, sends framed requests, collects replies
// Assumes: one character per rx_valid pulse, reply taken on tx_ready
// Notes: slow mode toggles tx_ready to stretch the reply

`timescale 1ns/1ps
`default_nettype none

module master_model (
  input wire logic core_clk,
  output logic rx_valid,
  output logic [7:0] rx_byte,
  output logic tx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte
);
  logic [7:0] rep[$];
  logic slow = 1'b0;
  initial begin
    rx_valid = 1'b0;
    rx_byte = 8'h00;
    tx_ready = 1'b0;
  end
  function automatic logic [15:0] crc(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (q[i]) begin
      c ^= {8'h00, q[i]};
      repeat (8) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
    end
    return c;
  endfunction : crc
  // Bad flips one CRC bit; gaps stay far under the limit
  task automatic xfer(input logic [7:0] q[$], input bit bad);
    logic [15:0] c;
    c = crc(q) ^ {15'h0000, bad};
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    rep.delete();
    foreach (q[i]) begin
      @(posedge core_clk);
      rx_valid <= 1'b1;
      rx_byte <= q[i];
      @(posedge core_clk);
      rx_valid <= 1'b0;
      rx_byte <= ~q[i];
      repeat (2) @(posedge core_clk);
    end
    repeat (300) begin
      @(negedge core_clk);
      if (tx_valid === 1'b1 && tx_ready === 1'b1) rep.push_back(tx_byte);
      @(posedge core_clk);
      tx_ready <= slow ? ~tx_ready : 1'b1;
    end
    tx_ready <= 1'b0;
  endtask : xfer
endmodule : master_model

`default_nettype wire

/* File: tb_serial_param_commit.sv */
// Purpose: request sequences with expected replies and strobes
// Assumes: station address 01, rd_data fixed at 1234
// Notes: exception replies are checked by length and code bytes, plus the data word of the first read

`timescale 1ns/1ps
`default_nettype none

module tb_serial_param_commit;
  import serial_cmd_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic bit_tick = 1'b0;
  logic err_reset = 1'b0;
  drive_status_t drive = '0;
  logic fault_new = 1'b0;
  logic [7:0] fault_code = 8'h00;
  logic rx_valid, tx_valid, tx_ready, stage_we, ref_we, commit_nv, commit_ram;
  logic [7:0] rx_byte, tx_byte, comm_err, fault_trace;
  logic [15:0] rd_addr;
  rx_flags_t rx_flags = '0;
  wr_port_t stage_wr, ref_wr;
  int fail_count = 0;
  int compares = 0;
  int nv_n = 0;
  int ram_n = 0;
  int st_n = 0;
  int rf_n = 0;
  logic [7:0] xc[4] = '{EXC_MODE, EXC_UV, EXC_MODE, EXC_BUSY};
  initial forever #25 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    bit_tick <= ~bit_tick;
    nv_n += int'(commit_nv === 1'b1);
    ram_n += int'(commit_ram === 1'b1);
    st_n += int'(stage_we === 1'b1);
    rf_n += int'(ref_we === 1'b1);
  end
  master_model u_master (.core_clk(core_clk), .rx_valid(rx_valid),
    .rx_byte(rx_byte), .tx_ready(tx_ready), .tx_valid(tx_valid),
    .tx_byte(tx_byte));
  serial_param_commit u_serial_param_commit (.core_clk(core_clk),
    .rst_n(rst_n), .slave_addr(8'h01), .bit_tick(bit_tick),
    .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_flags(rx_flags),
    .err_reset(err_reset), .drive(drive), .fault_new(fault_new),
    .fault_code(fault_code), .fault_clear(1'b0), .rd_addr(rd_addr),
    .rd_data(16'h1234), .tx_valid(tx_valid), .tx_byte(tx_byte),
    .tx_ready(tx_ready), .stage_wr(stage_wr), .stage_we(stage_we),
    .ref_wr(ref_wr), .ref_we(ref_we), .commit_nv(commit_nv),
    .commit_ram(commit_ram), .comm_err(comm_err),
    .fault_trace(fault_trace));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic req(input logic [7:0] f, input logic [15:0] a, n);
    u_master.xfer('{8'h01, f, a[15:8], a[7:0], n[15:8], n[7:0]}, 1'b0);
  endtask : req
  task automatic wr(input logic [7:0] s, input logic [15:0] a, d);
    u_master.xfer('{s, 8'h10, a[15:8], a[7:0], 8'h00, 8'h01, 8'h02,
      d[15:8], d[7:0]}, 1'b0);
  endtask : wr
  task automatic exc(input logic [7:0] f, input logic [7:0] code);
    chk(16'(u_master.rep.size()), 16'h0005);
    chk({u_master.rep[1], u_master.rep[2]}, {f | EXC_FLAG, code});
  endtask : exc
  task automatic stop_test();
    if (fail_count == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test
  initial begin
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    u_master.slow = 1'b1;
    req(FC_READ, 16'h0020, 16'h0001);
    chk({u_master.rep[3], u_master.rep[4]}, 16'h1234);
    chk(rd_addr, 16'h0020);
    u_master.slow = 1'b0;
    req(FC_READ, ADDR_COMMIT_NV, 16'h0001);
    exc(FC_READ, EXC_REG);
    req(8'h05, 16'h0020, 16'h0001);
    exc(8'h05, EXC_FUNC);
    req(FC_READ, 16'h0020, 16'h0011);
    exc(FC_READ, EXC_QTY);
    req(FC_READ, 16'h0050, 16'h0001);
    exc(FC_READ, EXC_REG);
    wr(8'h01, 16'h0100, 16'h0005);
    chk(16'(st_n), 16'h0001);
    chk(stage_wr, {16'h0100, 16'h0005});
    chk(16'(nv_n + ram_n), 16'h0000);
    wr(8'h01, ADDR_COMMIT_NV, 16'h0000);
    chk(16'(nv_n), 16'h0001);
    wr(8'h01, ADDR_COMMIT_RAM, 16'h0000);
    chk(16'({nv_n, ram_n} == {32'd1, 32'd1}), 16'h0001);
    u_master.xfer('{8'h01, 8'h10, 8'h01, 8'h00, 8'h00, 8'h01, 8'h04,
      8'h00, 8'h05, 8'h00, 8'h06}, 1'b0);
    exc(FC_WRITE, EXC_QTY);
    wr(8'h01, ADDR_COMMIT_RAM, 16'h0001);
    exc(FC_WRITE, 8'h21);
    chk(16'(ram_n), 16'h0001);
    wr(8'h00, 16'h0003, 16'h0007);
    wr(8'h00, ADDR_BCAST_A, 16'h0007);
    chk(16'(rf_n), 16'h0001);
    chk(ref_wr, {ADDR_BCAST_A, 16'h0007});
    for (int i = 0; i < 4; i++) begin
      drive <= drive_status_t'(4'b1000 >> i);
      wr(8'h01, 16'h0200, 16'h0001);
      exc(FC_WRITE, xc[i]);
    end
    drive <= '0;
    u_master.xfer('{8'h01, 8'h03, 8'h00, 8'h20, 8'h00, 8'h01}, 1'b1);
    chk(16'(u_master.rep.size()), 16'h0000);
    chk({8'h00, comm_err}, 16'h0001);
    rx_flags <= 3'b001;
    req(FC_READ, 16'h0020, 16'h0001);
    rx_flags <= 3'b000;
    chk(16'(u_master.rep.size()), 16'h0000);
    u_master.xfer('{8'h01, 8'h10, 8'h01, 8'h00, 8'h00, 8'h01, 8'hFF},
      1'b0);
    chk(16'(u_master.rep.size()), 16'h0000);
    u_master.xfer('{8'h01, 8'h03}, 1'b0);
    chk(16'(u_master.rep.size()), 16'h0000);
    chk({8'h00, comm_err}, 16'h004B);
    err_reset <= 1'b1;
    @(posedge core_clk);
    err_reset <= 1'b0;
    @(negedge core_clk);
    chk({8'h00, comm_err}, 16'h0000);
    fault_new <= 1'b1;
    fault_code <= FAULT_POWER_UNIT;
    @(posedge core_clk);
    fault_new <= 1'b0;
    repeat (3) @(negedge core_clk);
    chk({8'h00, fault_trace}, 16'h0001);
    stop_test();
  end
endmodule : tb_serial_param_commit

`default_nettype wire
